// ### hdl/srw_top.sv
// Supervisor: timed reset, debounced manual reset, watchdog and power-fail flag.
`timescale 1ns/10ps
`default_nettype none
module srw_top #(
    parameter int RST_PULSE_CYC = srw_pkg::RST_PULSE_CYC,
    parameter int WDOG_TIMEOUT_CYC = srw_pkg::WDOG_TIMEOUT_CYC,
    parameter bit WDOG_PRESENT = 1'b1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Comparator and pin inputs.
    input wire logic supply_low,
    input wire logic power_fail_sense,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick,
    input wire logic watchdog_kick_float,
    // Outputs toward the processor.
    output logic reset_n,
    output logic reset_hi,
    output logic watchdog_expired_n,
    output logic power_fail_flag_n
);
    import srw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic supply_low_s;
    logic pf_sense_s;
    logic mr_s;
    logic kick_s;
    logic kick_float_s;

    // Every comparator and pin passes two flops before any logic sees it.
    // The manual reset bit starts at its released level so the filter sees no false press after reset.
    assign pins = {watchdog_kick_float, watchdog_kick, manual_reset_n, power_fail_sense, supply_low};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 5'h07;
            sync2_ff <= 5'h07;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
        end
    end
    assign supply_low_s = sync2_ff[0];
    assign pf_sense_s = sync2_ff[1];
    assign mr_s = sync2_ff[2];
    assign kick_s = sync2_ff[3];
    assign kick_float_s = sync2_ff[4];

    ////////////////////////////////////////////////////////////////////////////////
    // Manual reset glitch filter.
    logic mr_db_ff;
    logic nxt_mr_db;
    srw_flt_type flt_cnt_ff;
    srw_flt_type nxt_flt_cnt;

    // A level must stand for the filter time before it is believed; longer bounces
    // are absorbed because each low restarts the reset stretch below.
    always_comb begin
        nxt_mr_db = mr_db_ff;
        nxt_flt_cnt = '0;
        if (mr_s != mr_db_ff) begin
            if (flt_cnt_ff == FLT_W'(MR_FILTER_CYC - 1)) begin
                nxt_mr_db = mr_s;
            end else begin
                nxt_flt_cnt = flt_cnt_ff + 3'h1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mr_db_ff <= MR_DB_INIT;
            flt_cnt_ff <= '0;
        end else begin
            mr_db_ff <= nxt_mr_db;
            flt_cnt_ff <= nxt_flt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset sequencer.
    srw_state_type state_ff;
    srw_state_type nxt_state;
    srw_cnt_type rst_cnt_ff;
    srw_cnt_type nxt_rst_cnt;
    logic reset_cause;
    logic reset_n_ff;
    logic reset_hi_ff;

    // Watchdog expiry is not a cause; it reaches here only through the pin.
    assign reset_cause = supply_low_s | ~mr_db_ff;

    // Hold while a cause stands, then stretch, then release.
    always_comb begin
        nxt_state = state_ff;
        nxt_rst_cnt = '0;
        case (state_ff)
            SRW_HOLD: begin
                if (!reset_cause) begin
                    nxt_state = SRW_STRETCH;
                end
            end
            SRW_STRETCH: begin
                if (reset_cause) begin
                    nxt_state = SRW_HOLD;
                end else if (rst_cnt_ff == CNT_W'(RST_PULSE_CYC - 1)) begin
                    nxt_state = SRW_RUN;
                end else begin
                    nxt_rst_cnt = rst_cnt_ff + 26'h1;
                end
            end
            SRW_RUN: begin
                if (reset_cause) begin
                    nxt_state = SRW_HOLD;
                end
            end
            default: begin
                nxt_state = SRW_HOLD;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SRW_HOLD;
            rst_cnt_ff <= '0;
            reset_n_ff <= RST_N_INIT;
            reset_hi_ff <= ~RST_N_INIT;
        end else begin
            state_ff <= nxt_state;
            rst_cnt_ff <= nxt_rst_cnt;
            reset_n_ff <= (nxt_state == SRW_RUN);
            reset_hi_ff <= (nxt_state != SRW_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog.
    logic kick_prev_ff;
    srw_cnt_type wd_cnt_ff;
    srw_cnt_type nxt_wd_cnt;
    logic wd_exp_ff;
    logic nxt_wd_exp;
    logic wdo_n_ff;
    logic pfo_n_ff;
    logic kick_edge;
    logic wd_clear;

    assign kick_edge = kick_s ^ kick_prev_ff;
    // Clearing follows the next reset state so counter and reset output line up.
    assign wd_clear = kick_edge | kick_float_s | (nxt_state != SRW_RUN) | ~WDOG_PRESENT;

    // A kick landing on the timeout cycle wins: the processor was just in time.
    always_comb begin
        nxt_wd_cnt = wd_cnt_ff;
        nxt_wd_exp = wd_exp_ff;
        if (wd_clear) begin
            nxt_wd_cnt = '0;
            nxt_wd_exp = 1'b0;
        end else if (!wd_exp_ff) begin
            if (wd_cnt_ff == CNT_W'(WDOG_TIMEOUT_CYC - 1)) begin
                nxt_wd_exp = 1'b1;
            end else begin
                nxt_wd_cnt = wd_cnt_ff + 26'h1;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            kick_prev_ff <= 1'b0;
            wd_cnt_ff <= '0;
            wd_exp_ff <= 1'b0;
            wdo_n_ff <= WDO_N_INIT;
            pfo_n_ff <= PFO_N_INIT;
        end else begin
            kick_prev_ff <= kick_s;
            wd_cnt_ff <= nxt_wd_cnt;
            wd_exp_ff <= nxt_wd_exp;
            wdo_n_ff <= ~(nxt_wd_exp | supply_low_s);
            pfo_n_ff <= pf_sense_s;
        end
    end

    // Registered outputs.
    assign reset_n = reset_n_ff;
    assign reset_hi = reset_hi_ff;
    assign watchdog_expired_n = wdo_n_ff;
    assign power_fail_flag_n = pfo_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_kick_steady;
        !kick_edge && !kick_float_s && reset_n_ff && !reset_cause;
    endsequence
    sequence s_supply_back;
        !supply_low_s ##1 !wd_exp_ff;
    endsequence

    AST_MR_STARTS_RESET: assert property (!mr_db_ff |=> !reset_n_ff)
        else $error("manual reset did not assert reset");
    AST_MR_FILTERED: assert property ($changed(mr_db_ff) |-> $past(flt_cnt_ff) == FLT_W'(MR_FILTER_CYC - 1))
        else $error("manual reset changed before filter time");
    AST_PF_FLAG: assert property ($past(rst_n) |-> pfo_n_ff == $past(pf_sense_s))
        else $error("power fail flag does not follow sense");
    AST_WDOG_EXPIRES: assert property ($rose(wd_exp_ff) |-> $past(wd_cnt_ff) == CNT_W'(WDOG_TIMEOUT_CYC - 1))
        else $error("watchdog expired at wrong count");
    AST_KICK_CLEARS: assert property (kick_edge |=> wd_cnt_ff == '0 && !wd_exp_ff)
        else $error("kick edge did not clear watchdog");
    AST_CLEAR_IN_RESET: assert property (!reset_n_ff |-> wd_cnt_ff == '0 && !wd_exp_ff)
        else $error("watchdog counted during reset");
    AST_FLOAT_DISABLES: assert property (kick_float_s |=> wd_cnt_ff == '0 && !wd_exp_ff)
        else $error("floating kick did not disable watchdog");
    AST_PULSE_LENGTH: assert property ($rose(reset_n_ff) |-> $past(rst_cnt_ff) == CNT_W'(RST_PULSE_CYC - 1))
        else $error("reset released before pulse time");
    AST_SUPPLY_HOLDS: assert property (supply_low_s |=> !reset_n_ff [*2])
        else $error("reset released during low supply");
    AST_STRETCH_START: assert property ($fell(reset_cause) |-> !reset_n_ff ##1 !reset_n_ff)
        else $error("reset not stretched after cause cleared");
    AST_NO_WDOG_RESET: assert property ($rose(wd_exp_ff) |-> reset_n_ff)
        else $error("expiry coincided with reset");
    AST_EXP_HOLD: assert property ((s_kick_steady and wd_exp_ff) |=> wd_exp_ff)
        else $error("expiry dropped without a clear");
    AST_LOWLINE_WDO: assert property (supply_low_s |=> !wdo_n_ff)
        else $error("expired output not forced low on low supply");
    AST_WDO_RECOVER: assert property (s_supply_back |-> wdo_n_ff)
        else $error("expired output not released after supply recovery");
    AST_COMPLEMENT: assert property (reset_hi_ff == !reset_n_ff)
        else $error("active high reset is not the complement");
    AST_TIMING_AFTER_RESET: assert property ($rose(reset_n_ff) |-> wd_cnt_ff <= CNT_W'(1) && !wd_exp_ff)
        else $error("watchdog timing started before reset release");
endmodule
`default_nettype wire

// ### hdl/srw_pkg.sv
// Shared constants and types for the supervisor reset and watchdog block.
package srw_pkg;
    // Reference clock.
    localparam int CLK_HZ = 40000000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int CLK_MHZ = CLK_HZ / 1000000;
    // Reset pulse stretch after the last cause clears.
    localparam int RST_PULSE_MS = 200;
    localparam int RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;
    // Watchdog timeout measured from the last counter clear.
    localparam int WDOG_TIMEOUT_MS = 1600;
    localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * CLK_KHZ;
    // Glitch filter on the manual reset pin, a least time so it rounds up.
    localparam int MR_FILTER_NS = 100;
    localparam int MR_FILTER_CYC = (MR_FILTER_NS * CLK_MHZ + 999) / 1000;
    // Counter widths.
    localparam int CNT_W = 26;
    localparam int FLT_W = 3;
    // Reset values of the registered outputs and of the manual reset filter.
    localparam logic RST_N_INIT = 1'h0;
    localparam logic WDO_N_INIT = 1'h0;
    localparam logic PFO_N_INIT = 1'h0;
    localparam logic MR_DB_INIT = 1'h1;
    typedef logic [CNT_W-1:0] srw_cnt_type;
    typedef logic [FLT_W-1:0] srw_flt_type;
    // Reset sequencer states.
    typedef enum logic [1:0] {
        SRW_HOLD = 2'h0,
        SRW_STRETCH = 2'h1,
        SRW_RUN = 2'h2
    } srw_state_type;
endpackage

// ### tb/srw_cpu_model.sv
// Processor-side model that toggles the watchdog kick while it runs.
`timescale 1ns/10ps
`default_nettype none
module srw_cpu_model #(
    parameter int KICK_PERIOD = 30
) (
    // Clock.
    input wire logic clk_sys,
    // Reset from the supervisor.
    input wire logic reset_n,
    // Bench control and kick line.
    input wire logic kick_en,
    output logic watchdog_kick
);
    int kick_cnt = 0;
    logic kick_ff = 1'h0;

    // The kick line starts from a known low level.
    assign watchdog_kick = kick_ff;

    // Software stops while reset is held, so kicks stop too; the period stays under the timeout.
    always @(posedge clk_sys) begin
        if (!kick_en || !reset_n) begin
            kick_cnt <= 0;
        end else if (kick_cnt == 0) begin
            kick_ff <= ~kick_ff;
            kick_cnt <= KICK_PERIOD - 1;
        end else begin
            kick_cnt <= kick_cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ### tb/srw_top_tb.sv
// Self-checking testbench for the supervisor reset and watchdog block.
`timescale 1ns/10ps
`default_nettype none
module srw_top_tb;
    logic clk_sys = 1'h0, rst_n = 1'h0, supply_low = 1'h1, power_fail_sense = 1'h1;
    logic manual_reset_n = 1'h1, watchdog_kick_float = 1'h0, kick_en = 1'h0;
    logic watchdog_kick, reset_n, reset_hi, watchdog_expired_n, power_fail_flag_n, rst_prev;
    int err_count = 0, n_tests = 0, cyc_cnt = 0, rises = 0, r0;

    srw_top #(.RST_PULSE_CYC(20), .WDOG_TIMEOUT_CYC(50), .WDOG_PRESENT(1'b1)) srw_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .supply_low(supply_low), .power_fail_sense(power_fail_sense),
        .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick),
        .watchdog_kick_float(watchdog_kick_float), .reset_n(reset_n), .reset_hi(reset_hi),
        .watchdog_expired_n(watchdog_expired_n), .power_fail_flag_n(power_fail_flag_n));
    srw_cpu_model srw_cpu_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .kick_en(kick_en),
        .watchdog_kick(watchdog_kick));

    always #12.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    // Closing report, reached from the main sequence or the timeout.
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic seen, logic exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Wait n rising edges, then sample at the falling edge where outputs have settled.
    task cyc(int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // A hang must not run forever; the whole sequence needs well under a thousand cycles.
    always @(posedge clk_sys) begin
        cyc_cnt++;
        rst_prev <= reset_n;
        if (rst_n && reset_n === 1'h1 && rst_prev === 1'h0) rises++;
        if (cyc_cnt == 3000) begin
            err_count++;
            wrap_up;
        end
    end

    // The two reset outputs are compared on every cycle out of reset.
    always @(negedge clk_sys) if (rst_n) check("reset_hi", reset_hi, ~reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    task t_power_up;
        @(posedge clk_sys) supply_low <= 1'h0;
        cyc(2); check("wdo low supply", watchdog_expired_n, 1'h0);
        cyc(1); check("wdo recovered", watchdog_expired_n, 1'h1);
        cyc(19); check("reset stretch", reset_n, 1'h0);
        cyc(1); check("reset release", reset_n, 1'h1);
        cyc(48); check("wdo before timeout", watchdog_expired_n, 1'h1);
        cyc(1); check("wdo timeout", watchdog_expired_n, 1'h0);
        cyc(20); check("wdo held", watchdog_expired_n, 1'h0);
        check("no reset on expiry", reset_n, 1'h1);
        @(posedge clk_sys) kick_en <= 1'h1;
        cyc(4); check("kick clears wdo", watchdog_expired_n, 1'h1);
        cyc(200); check("kicked wdo", watchdog_expired_n, 1'h1);
        $display("test power_up done");
    endtask

    task t_float_pfail;
        @(posedge clk_sys) kick_en <= 1'h0;
        watchdog_kick_float <= 1'h1;
        power_fail_sense <= 1'h0;
        cyc(3); check("pfo low", power_fail_flag_n, 1'h0);
        @(posedge clk_sys) power_fail_sense <= 1'h1;
        cyc(3); check("pfo high", power_fail_flag_n, 1'h1);
        cyc(150); check("floating kick", watchdog_expired_n, 1'h1);
        @(posedge clk_sys) watchdog_kick_float <= 1'h0;
        $display("test float_pfail done");
    endtask

    task t_manual;
        @(posedge clk_sys) manual_reset_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        manual_reset_n <= 1'h1;
        cyc(12); check("glitch ignored", reset_n, 1'h1);
        r0 = rises;
        @(posedge clk_sys) manual_reset_n <= 1'h0;
        repeat (10) @(posedge clk_sys);
        manual_reset_n <= 1'h1;
        repeat (5) @(posedge clk_sys);
        manual_reset_n <= 1'h0;
        cyc(9); check("manual reset", reset_n, 1'h0);
        @(posedge clk_sys) manual_reset_n <= 1'h1;
        cyc(24); check("manual stretch", reset_n, 1'h0);
        cyc(6); check("manual release", reset_n, 1'h1);
        check("one reset event", (rises - r0) == 1, 1'h1);
        cyc(40); check("timer restarted", watchdog_expired_n, 1'h1);
        $display("test manual done");
    endtask

    task t_brownout;
        @(posedge clk_sys) supply_low <= 1'h1;
        cyc(3); check("brownout reset", reset_n, 1'h0);
        check("brownout wdo", watchdog_expired_n, 1'h0);
        cyc(30); check("reset held low", reset_n, 1'h0);
        @(posedge clk_sys) supply_low <= 1'h0;
        cyc(30); check("reset after brownout", reset_n, 1'h1);
        $display("test brownout done");
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        cyc(4);
        check("reset at power up", reset_n, 1'h0);
        t_power_up;
        t_float_pfail;
        t_manual;
        t_brownout;
        wrap_up;
    end
endmodule
`default_nettype wire
